// ### design/fhc_flash_host.sv
`timescale 1ns/1ps
// What this block does
// - host polls erase status at an address inside an erasing sector.
// - polling bit may flip early; host reads again for valid data.
// - programming 1 over 0 locks; timeout rises; host must reset device.
// - busy after fourth or sixth write; host ignores it during reset.
// - reset low at least 500 ns; ready 20 us after fall, 50 ns after rise.
// - command writes are byte wide on the low eight data pins.
module fhc_flash_host (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic [18:0]      fl_addr,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  output logic             fl_reset_n,
  output logic             fl_byte_n,
  input  wire logic [15:0] fl_dq_in,
  output logic [15:0]      fl_dq_out,
  output logic [15:0]      fl_dq_oe,
  input  wire logic        ready_busy_n
);
  // ****************************************
  // state
  // ****************************************
  fhc_pkg::fhc_state_t st_reg, st_next;
  fhc_pkg::fhc_op_t    op_reg, op_next;
  logic        word_reg, word_next;
  logic [19:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [2:0]  step_reg, step_next;
  logic [10:0] cnt_reg, cnt_next;
  logic [15:0] first_reg, first_next;
  logic [15:0] data_reg, data_next;
  logic        done_reg, done_next;
  logic        fail_reg, fail_next;
  logic        tmo_reg, tmo_next;
  logic        etmr_reg, etmr_next;
  logic        refused_reg, refused_next;
  logic        ready_reg, ready_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        bus_req, bus_wr, bus_cmd, bus_m1, bus_done;
  logic [18:0] bus_a;
  logic [15:0] bus_wdata, bus_rdata;
  logic [18:0] seq_a;
  logic        seq_m1, seq_cmd, seq_last;
  logic [7:0]  seq_d;
  logic        in_reset, toggled, go, needs_ready;
  logic [15:0] status;

  // ****************************************
  // command sequence table
  // ****************************************
  // unlock addresses are word addresses; in byte mode the low address bit
  // rides on the top data pin, so the same table serves both widths
  always_comb begin
    seq_a    = fhc_pkg::UNLOCK_A1;
    seq_m1   = 1'b0;
    seq_d    = fhc_pkg::CMD_UNLOCK1;
    seq_cmd  = 1'b1;
    seq_last = 1'b0;
    case (op_reg)
      fhc_pkg::OP_PROG, fhc_pkg::OP_CHIP, fhc_pkg::OP_SECT: begin
        case (step_reg)
          3'h1, 3'h4: begin
            seq_a  = fhc_pkg::UNLOCK_A2;
            seq_m1 = 1'b1;
            seq_d  = fhc_pkg::CMD_UNLOCK2;
          end
          3'h2: begin
            seq_d = (op_reg == fhc_pkg::OP_PROG) ? fhc_pkg::CMD_PROG : fhc_pkg::CMD_SETUP;
          end
          3'h3: begin
            if (op_reg == fhc_pkg::OP_PROG) begin
              // fourth write carries the user data, all 16 bits in word mode, low byte in byte mode
              seq_a    = addr_reg[19:1];
              seq_m1   = addr_reg[0];
              seq_cmd  = 1'b0;
              seq_last = 1'b1;
            end
          end
          3'h5: begin
            seq_last = 1'b1;
            if (op_reg == fhc_pkg::OP_SECT) begin
              seq_a  = addr_reg[19:1];
              seq_m1 = addr_reg[0];
              seq_d  = fhc_pkg::CMD_SECT;
            end else begin
              seq_d = fhc_pkg::CMD_CHIP;
            end
          end
          default: begin
            seq_d = fhc_pkg::CMD_UNLOCK1;
          end
        endcase
      end
      fhc_pkg::OP_SECT_ADD, fhc_pkg::OP_RESUME: begin
        seq_a    = addr_reg[19:1];
        seq_m1   = addr_reg[0];
        seq_d    = fhc_pkg::CMD_SECT;
        seq_last = 1'b1;
      end
      fhc_pkg::OP_SUSP: begin
        seq_d    = fhc_pkg::CMD_SUSP;
        seq_last = 1'b1;
      end
      default: begin
        seq_last = 1'b1;
      end
    endcase
  end

  // ****************************************
  // operation sequencer
  // ****************************************
  assign in_reset    = (st_reg == fhc_pkg::S_RST_LO) || (st_reg == fhc_pkg::S_RST_HI);
  assign toggled     = first_reg[fhc_pkg::TOG_BIT] ^ bus_rdata[fhc_pkg::TOG_BIT];
  assign go          = reg_wr && (reg_addr == fhc_pkg::REG_CTRL)
                       && reg_wdata[fhc_pkg::CTRL_GO_BIT];
  assign needs_ready = (reg_wdata[2:0] == fhc_pkg::OP_PROG)
                       || (reg_wdata[2:0] == fhc_pkg::OP_CHIP)
                       || (reg_wdata[2:0] == fhc_pkg::OP_SECT);

  // polls always use the operation address, which for erase must lie in an
  // unprotected erasing sector; the host cannot check that, software must
  always_comb begin
    st_next      = st_reg;
    op_next      = op_reg;
    word_next    = word_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    step_next    = step_reg;
    cnt_next     = cnt_reg;
    first_next   = first_reg;
    data_next    = data_reg;
    done_next    = done_reg;
    fail_next    = fail_reg;
    tmo_next     = tmo_reg;
    etmr_next    = etmr_reg;
    refused_next = refused_reg;
    // busy pin means nothing while the reset pin is low
    ready_next   = in_reset ? 1'b0 : ready_busy_n;
    case (st_reg)
      fhc_pkg::S_IDLE: begin
        if (reg_wr && reg_addr == fhc_pkg::REG_ADDR) begin
          addr_next = reg_wdata[19:0];
        end
        if (reg_wr && reg_addr == fhc_pkg::REG_WDATA) begin
          wdata_next = reg_wdata[15:0];
        end
        if (reg_wr && reg_addr == fhc_pkg::REG_CTRL) begin
          word_next = reg_wdata[fhc_pkg::CTRL_WORD_BIT];
        end
        if (go) begin
          op_next      = fhc_pkg::fhc_op_t'(reg_wdata[2:0]);
          step_next    = 3'h0;
          cnt_next     = 11'h000;
          refused_next = 1'b0;
          if (needs_ready && !ready_reg) begin
            // device busy: program and erase commands are refused, all others go out
            refused_next = 1'b1;
          end else begin
            done_next = 1'b0;
            fail_next = 1'b0;
            tmo_next  = 1'b0;
            case (reg_wdata[2:0])
              fhc_pkg::OP_READ:   st_next = fhc_pkg::S_FINAL;
              fhc_pkg::OP_HRESET: st_next = fhc_pkg::S_RST_LO;
              default:            st_next = fhc_pkg::S_CMD;
            endcase
          end
        end
      end
      fhc_pkg::S_CMD: begin
        if (bus_done) begin
          step_next = step_reg + 3'h1;
          if (seq_last) begin
            case (op_reg)
              fhc_pkg::OP_PROG, fhc_pkg::OP_CHIP, fhc_pkg::OP_SECT: begin
                st_next = fhc_pkg::S_POLL_A;
              end
              fhc_pkg::OP_SECT_ADD: st_next = fhc_pkg::S_FINAL;
              fhc_pkg::OP_SUSP: begin
                st_next  = fhc_pkg::S_WAIT;
                cnt_next = 11'h000;
              end
              default: begin
                st_next   = fhc_pkg::S_IDLE;
                done_next = 1'b1;
              end
            endcase
          end
        end
      end
      fhc_pkg::S_POLL_A: begin
        if (bus_done) begin
          first_next = bus_rdata;
          st_next    = fhc_pkg::S_POLL_B;
        end
      end
      fhc_pkg::S_POLL_B: begin
        if (bus_done) begin
          st_next = fhc_pkg::S_EVAL;
        end
      end
      fhc_pkg::S_EVAL: begin
        etmr_next = bus_rdata[fhc_pkg::ETMR_BIT];
        if (!toggled) begin
          // toggling stopped; a fresh read gives trustworthy data
          st_next = fhc_pkg::S_FINAL;
        end else if (tmo_reg) begin
          // still toggling after the timeout flag: locked, reset it
          fail_next = 1'b1;
          cnt_next  = 11'h000;
          st_next   = fhc_pkg::S_RST_LO;
        end else begin
          // on timeout, poll once more since toggling may stop with it
          tmo_next = bus_rdata[fhc_pkg::TMO_BIT];
          st_next  = fhc_pkg::S_POLL_A;
        end
      end
      fhc_pkg::S_FINAL: begin
        if (bus_done) begin
          // re-read after toggling stopped; earlier low bits may be stale
          data_next = bus_rdata;
          etmr_next = bus_rdata[fhc_pkg::ETMR_BIT];
          st_next   = fhc_pkg::S_IDLE;
          done_next = 1'b1;
          if (op_reg == fhc_pkg::OP_PROG) begin
            fail_next = bus_rdata[fhc_pkg::POLL_BIT] != wdata_reg[fhc_pkg::POLL_BIT];
          end else if (op_reg == fhc_pkg::OP_CHIP || op_reg == fhc_pkg::OP_SECT) begin
            fail_next = !bus_rdata[fhc_pkg::POLL_BIT];
          end
        end
      end
      fhc_pkg::S_WAIT: begin
        // device may take this long to enter suspend
        cnt_next = cnt_reg + 11'h001;
        if (cnt_reg == 11'(fhc_pkg::SUSP_CYC - 1)) begin
          st_next   = fhc_pkg::S_IDLE;
          done_next = 1'b1;
        end
      end
      fhc_pkg::S_RST_LO: begin
        cnt_next = cnt_reg + 11'h001;
        if (cnt_reg == 11'(fhc_pkg::RP_CYC - 1)) begin
          st_next = fhc_pkg::S_RST_HI;
        end
      end
      fhc_pkg::S_RST_HI: begin
        // counted from the falling edge; covers 20 us and the 50 ns recovery
        cnt_next = cnt_reg + 11'h001;
        if (cnt_reg == 11'(fhc_pkg::RST_CYC - 1)) begin
          st_next   = fhc_pkg::S_IDLE;
          done_next = 1'b1;
        end
      end
      default: begin
        st_next = fhc_pkg::S_IDLE;
      end
    endcase
  end

  // ****************************************
  // register read port
  // ****************************************
  assign status = {9'h000, refused_reg, ready_reg, etmr_reg, tmo_reg, fail_reg,
                   done_reg, (st_reg != fhc_pkg::S_IDLE)};

  // read data stand one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdat_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        fhc_pkg::REG_CTRL:   rdat_next = {27'h0, word_reg, 1'b0, op_reg};
        fhc_pkg::REG_ADDR:   rdat_next = {12'h000, addr_reg};
        fhc_pkg::REG_WDATA:  rdat_next = {16'h0000, wdata_reg};
        fhc_pkg::REG_STATUS: rdat_next = {16'h0000, status};
        fhc_pkg::REG_RDATA:  rdat_next = {16'h0000, data_reg};
        default:             rdat_next = 32'h0000_0000;
      endcase
    end
  end

  // registers of the controller
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg      <= fhc_pkg::S_IDLE;
      op_reg      <= fhc_pkg::OP_READ;
      word_reg    <= fhc_pkg::WORD_RST;
      addr_reg    <= 20'h00000;
      wdata_reg   <= 16'h0000;
      step_reg    <= 3'h0;
      cnt_reg     <= 11'h000;
      first_reg   <= 16'h0000;
      data_reg    <= 16'h0000;
      done_reg    <= 1'b0;
      fail_reg    <= 1'b0;
      tmo_reg     <= 1'b0;
      etmr_reg    <= 1'b0;
      refused_reg <= 1'b0;
      ready_reg   <= 1'b0;
      rdat_reg    <= 32'h0000_0000;
    end else begin
      st_reg      <= st_next;
      op_reg      <= op_next;
      word_reg    <= word_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      step_reg    <= step_next;
      cnt_reg     <= cnt_next;
      first_reg   <= first_next;
      data_reg    <= data_next;
      done_reg    <= done_next;
      fail_reg    <= fail_next;
      tmo_reg     <= tmo_next;
      etmr_reg    <= etmr_next;
      refused_reg <= refused_next;
      ready_reg   <= ready_next;
      rdat_reg    <= rdat_next;
    end
  end

  // ****************************************
  // flash bus
  // ****************************************
  // request drops with done so the engine never starts a second cycle
  assign bus_req   = ((st_reg == fhc_pkg::S_CMD) || (st_reg == fhc_pkg::S_POLL_A)
                     || (st_reg == fhc_pkg::S_POLL_B) || (st_reg == fhc_pkg::S_FINAL))
                     && !bus_done;
  assign bus_wr    = (st_reg == fhc_pkg::S_CMD);
  assign bus_cmd   = seq_cmd;
  assign bus_a     = bus_wr ? seq_a : addr_reg[19:1];
  assign bus_m1    = bus_wr ? seq_m1 : addr_reg[0];
  assign bus_wdata = seq_cmd ? {8'h00, seq_d} : wdata_reg;

  fhc_bus_cycle u_bus (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .req       (bus_req),
    .wr        (bus_wr),
    .cmd       (bus_cmd),
    .word_mode (word_reg),
    .a         (bus_a),
    .a_m1      (bus_m1),
    .wdata     (bus_wdata),
    .done      (bus_done),
    .rdata     (bus_rdata),
    .fl_addr   (fl_addr),
    .fl_ce_n   (fl_ce_n),
    .fl_oe_n   (fl_oe_n),
    .fl_we_n   (fl_we_n),
    .fl_dq_in  (fl_dq_in),
    .fl_dq_out (fl_dq_out),
    .fl_dq_oe  (fl_dq_oe)
  );

  // no bus cycle runs in reset states, so the data pins stay undriven
  assign fl_reset_n = (st_reg != fhc_pkg::S_RST_LO);
  assign fl_byte_n  = word_reg;
  assign reg_rdata  = rdat_reg;
endmodule

// ### design/fhc_pkg.sv
package fhc_pkg;
  // ****************************************
  // timing, all counts from a 50 MHz clock
  // ****************************************
  localparam int CLK_NS     = 20;
  localparam int T_ACC_NS   = 70;     // read access, least wait
  localparam int T_WP_NS    = 40;     // write strobe width, least
  localparam int T_RP_NS    = 500;    // reset pin low, least
  localparam int T_RH_NS    = 50;     // reset high to first read, least
  localparam int T_READY_NS = 20000;  // reset fall to read mode, device longest
  localparam int T_SUSP_NS  = 20000;  // erase suspend latency, device longest
  localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC     = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC     = (T_RH_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_CYC  = (T_READY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSP_CYC   = (T_SUSP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC    = (READY_CYC > RP_CYC + RH_CYC) ? READY_CYC : RP_CYC + RH_CYC;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_GO_BIT  = 3;
  localparam int CTRL_WORD_BIT = 4;
  localparam logic WORD_RST   = 1'b1;
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_TMO     = 3;
  localparam int ST_ETMR    = 4;
  localparam int ST_READY   = 5;
  localparam int ST_REFUSED = 6;

  // ****************************************
  // flash status bits and command bytes
  // ****************************************
  localparam int POLL_BIT = 7;
  localparam int TOG_BIT  = 6;
  localparam int TMO_BIT  = 5;
  localparam int ETMR_BIT = 3;
  localparam logic [7:0]  CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CMD_SETUP   = 8'h80;
  localparam logic [7:0]  CMD_PROG    = 8'ha0;
  localparam logic [7:0]  CMD_CHIP    = 8'h10;
  localparam logic [7:0]  CMD_SECT    = 8'h30;
  localparam logic [7:0]  CMD_SUSP    = 8'hb0;
  localparam logic [7:0]  CMD_RESUME  = 8'h30;
  localparam logic [18:0] UNLOCK_A1   = 19'h00555;
  localparam logic [18:0] UNLOCK_A2   = 19'h002aa;

  typedef enum logic [2:0] {
    OP_READ     = 3'h0,
    OP_PROG     = 3'h1,
    OP_CHIP     = 3'h2,
    OP_SECT     = 3'h3,
    OP_SECT_ADD = 3'h4,
    OP_SUSP     = 3'h5,
    OP_RESUME   = 3'h6,
    OP_HRESET   = 3'h7
  } fhc_op_t;

  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_CMD    = 9'h002,
    S_POLL_A = 9'h004,
    S_POLL_B = 9'h008,
    S_EVAL   = 9'h010,
    S_FINAL  = 9'h020,
    S_WAIT   = 9'h040,
    S_RST_LO = 9'h080,
    S_RST_HI = 9'h100
  } fhc_state_t;

  typedef enum logic [3:0] {
    B_IDLE  = 4'h1,
    B_SETUP = 4'h2,
    B_STRB  = 4'h4,
    B_HOLD  = 4'h8
  } fhc_bstate_t;
endpackage

// ### design/fhc_bus_cycle.sv
`timescale 1ns/1ps
module fhc_bus_cycle (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic        cmd,
  input  wire logic        word_mode,
  input  wire logic [18:0] a,
  input  wire logic        a_m1,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [18:0]      fl_addr,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  input  wire logic [15:0] fl_dq_in,
  output logic [15:0]      fl_dq_out,
  output logic [15:0]      fl_dq_oe
);
  fhc_pkg::fhc_bstate_t st_reg, st_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic        wr_reg, wr_next;
  logic        done_reg, done_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [18:0] addr_reg, addr_next;
  logic        ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next;
  logic [15:0] dq_reg, dq_next, dqoe_reg, dqoe_next;
  logic [2:0]  len;

  // ****************************************
  // one bus cycle: setup, strobe, hold
  // ****************************************
  // every read drops and raises both oe and ce, so each poll is a fresh access
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    wr_next    = wr_reg;
    done_next  = 1'b0;
    rdata_next = rdata_reg;
    addr_next  = addr_reg;
    ce_next    = ce_reg;
    oe_next    = oe_reg;
    we_next    = we_reg;
    dq_next    = dq_reg;
    dqoe_next  = dqoe_reg;
    len        = wr_reg ? 3'(fhc_pkg::WP_CYC) : 3'(fhc_pkg::ACC_CYC);
    case (st_reg)
      fhc_pkg::B_IDLE: begin
        if (req) begin
          st_next   = fhc_pkg::B_SETUP;
          wr_next   = wr;
          addr_next = a;
          ce_next   = 1'b0;
          if (!word_mode) begin
            // byte mode: top pin carries the low address, bits 8..14 float
            dq_next   = {a_m1, 7'h00, wdata[7:0]};
            dqoe_next = wr ? 16'h80ff : 16'h8000;
          end else if (cmd) begin
            // commands are byte wide whatever the width
            dq_next   = {8'h00, wdata[7:0]};
            dqoe_next = wr ? 16'h00ff : 16'h0000;
          end else begin
            dq_next   = wdata;
            dqoe_next = wr ? 16'hffff : 16'h0000;
          end
        end
      end
      fhc_pkg::B_SETUP: begin
        st_next  = fhc_pkg::B_STRB;
        cnt_next = 3'h0;
        oe_next  = wr_reg;
        we_next  = !wr_reg;
      end
      fhc_pkg::B_STRB: begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == len - 3'h1) begin
          st_next = fhc_pkg::B_HOLD;
          oe_next = 1'b1;
          we_next = 1'b1;
          if (!wr_reg) begin
            rdata_next = word_mode ? fl_dq_in : {8'h00, fl_dq_in[7:0]};
          end
        end
      end
      fhc_pkg::B_HOLD: begin
        // data held one cycle past the strobe's rising edge
        st_next   = fhc_pkg::B_IDLE;
        ce_next   = 1'b1;
        dqoe_next = 16'h0000;
        done_next = 1'b1;
      end
      default: begin
        st_next = fhc_pkg::B_IDLE;
      end
    endcase
  end

  // registers of the bus cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg    <= fhc_pkg::B_IDLE;
      cnt_reg   <= 3'h0;
      wr_reg    <= 1'b0;
      done_reg  <= 1'b0;
      rdata_reg <= 16'h0000;
      addr_reg  <= 19'h00000;
      ce_reg    <= 1'b1;
      oe_reg    <= 1'b1;
      we_reg    <= 1'b1;
      dq_reg    <= 16'h0000;
      dqoe_reg  <= 16'h0000;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
      done_reg  <= done_next;
      rdata_reg <= rdata_next;
      addr_reg  <= addr_next;
      ce_reg    <= ce_next;
      oe_reg    <= oe_next;
      we_reg    <= we_next;
      dq_reg    <= dq_next;
      dqoe_reg  <= dqoe_next;
    end
  end

  assign done      = done_reg;
  assign rdata     = rdata_reg;
  assign fl_addr   = addr_reg;
  assign fl_ce_n   = ce_reg;
  assign fl_oe_n   = oe_reg;
  assign fl_we_n   = we_reg;
  assign fl_dq_out = dq_reg;
  assign fl_dq_oe  = dqoe_reg;
endmodule

// ### dv/fhc_flash_host_asserts.sv
`timescale 1ns/1ps
module fhc_chk (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        fl_ce_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_we_n,
  input wire logic        fl_reset_n,
  input wire logic        fl_byte_n,
  input wire logic [18:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic [15:0] fl_dq_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ****
  // flash pins
  // ****
  rst_width_a: assert property ($fell(fl_reset_n) |-> (!fl_reset_n)[*8] ##17 !fl_reset_n)
    else $error("reset pulse short");
  rst_quiet_a: assert property (!fl_reset_n |-> fl_dq_oe == 16'h0 && fl_we_n)
    else $error("drive in reset");
  lane_set_a: assert property (fl_dq_oe != 16'h0 |->
    fl_dq_oe inside {16'h00ff, 16'hffff, 16'h80ff, 16'h8000})
    else $error("bad lanes");
  byte_float_a: assert property (!fl_byte_n |-> fl_dq_oe[14:8] == 7'h0)
    else $error("upper lanes driven");
  wr_pulse_a: assert property ($fell(fl_we_n) |->
    !fl_ce_n && fl_oe_n && fl_dq_oe != 16'h0 ##1 !fl_we_n ##1 fl_we_n)
    else $error("bad write");
  rd_pulse_a: assert property ($fell(fl_oe_n) |->
    !fl_ce_n && fl_we_n && fl_dq_oe[7:0] == 8'h0 ##1 (!fl_oe_n)[*3] ##1 fl_oe_n)
    else $error("bad read");
  unlock_addr_a: assert property ($fell(fl_we_n) && fl_dq_oe == 16'h00ff &&
    fl_dq_out[7:0] == fhc_pkg::CMD_UNLOCK2 |-> fl_addr == fhc_pkg::UNLOCK_A2)
    else $error("unlock address wrong");
endmodule

// ### dv/fhc_flash_model.sv
`timescale 1ns/1ps
module fhc_flash_model (
  input  wire logic        fl_ce_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_reset_n,
  input  wire logic        fl_byte_n,
  input  wire logic [15:0] dq,
  input  wire logic [3:0]  busy_reads,
  output logic      [15:0] m_dq,
  output logic      [15:0] m_en,
  output logic             rb_n
);
  logic [15:0] mem_q = 16'hffff;
  logic [7:0]  c3 = 8'h0;
  logic [2:0]  n_wr = 3'h0;
  logic        erase = 1'b0, lock = 1'b0, tog = 1'b0, b7 = 1'b0, win = 1'b0;
  int          left = 0;
  // commands ignored while busy
  always @(posedge fl_we_n) if (!fl_ce_n && fl_reset_n && left == 0 && !lock) begin
    n_wr = n_wr + 3'h1;
    if (n_wr == 3'h3) c3 = dq[7:0];
    if (n_wr == 3'h4 && c3 == 8'ha0) begin
      b7 = ~dq[7];
      lock = |(dq & ~mem_q); // a 1 over a 0 never ends
      mem_q = mem_q & dq;
      erase = 1'b0;
      left = busy_reads;
      n_wr = 3'h0;
    end
    if (n_wr == 3'h6) begin
      b7 = 1'b0;
      erase = 1'b1;
      win = dq[7:0] == 8'h30; // a sector erase opens the acceptance window
      mem_q = 16'hffff;
      left = busy_reads;
      n_wr = 3'h0;
    end
  end
  // status per read while busy, set as oe falls
  always @(negedge fl_oe_n) if (!fl_ce_n && fl_reset_n) begin
    if (left != 0 || lock) begin
      tog = ~tog;
      m_dq = {8'h00, b7, tog, lock, 1'b0, erase & !win, erase & tog, 2'b00};
      win = 1'b0; // window kept open for one status read only, to keep runs short
      left = lock ? left : left - 1;
    end else m_dq = mem_q;
  end
  // upper lanes float in byte mode
  assign m_en = (!fl_oe_n && !fl_ce_n && fl_reset_n) ? (fl_byte_n ? 16'hffff : 16'h00ff) : 16'h0;
  assign rb_n = (left != 0 || lock) ? 1'b0 : 1'b1; // pull-up when idle
  // reset pin aborts at once, well inside the limit
  always @(negedge fl_reset_n) begin
    left = 0;
    lock = 1'b0;
    n_wr = 3'h0;
  end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic [18:0] fl_addr;
  logic        fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_byte_n, rb_n;
  logic [15:0] fl_dq_out, fl_dq_oe, m_dq, m_en, last = 16'h0;
  logic [3:0]  slow = 4'h0;
  int          failures = 0, tests_run = 0;
  // ctrl byte with go, program data, final data
  logic [39:0] rows [5] = '{40'h0a000000ff, 40'h1a0000ffff, 40'h195a3c5a3c,
                            40'h1b0000ffff, 40'h1912341234};
  // released lanes show the inverse of the last value
  wire  [15:0] fl_dq_in = m_en & m_dq | ~m_en & fl_dq_oe & fl_dq_out | ~m_en & ~fl_dq_oe & ~last;
  fhc_flash_host u_dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fl_addr, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n, .fl_byte_n, .fl_dq_in, .fl_dq_out,
    .fl_dq_oe, .ready_busy_n(rb_n));
  fhc_flash_model u_mem (.fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n, .fl_byte_n,
    .dq(fl_dq_out), .busy_reads(slow), .m_dq, .m_en, .rb_n);
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1 v = reg_rdata;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // bounded poll of the done flag
  task automatic run(input logic [7:0] c, input logic [15:0] d);
    bus(1'b1, fhc_pkg::REG_WDATA, {16'h0, d});
    bus(1'b1, fhc_pkg::REG_CTRL, {24'h0, c});
    for (int k = 0; k < 1500; k++) begin
      bus(1'b0, fhc_pkg::REG_STATUS, 32'h0);
      if (v[fhc_pkg::ST_DONE] === 1'b1) return;
    end
    failures++;
    print_verdict();
  endtask
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // held until reset ends so that floating lanes never stay unknown
  always @(posedge sys_clk) if (resetn) last <= fl_dq_in;
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    bus(1'b0, 8'h20, 32'h0);
    check(v, 32'h0);
    // prompt and slower device answers
    for (int i = 0; i < 5; i++) begin
      slow <= 4'(i);
      run(rows[i][39:32], rows[i][31:16]);
      check(v & 32'h6, 32'h2);
      bus(1'b0, fhc_pkg::REG_RDATA, 32'h0);
      check(v, {16'h0, rows[i][15:0]});
    end
    run(8'h19, 16'h00a5);
    check(v & 32'he, 32'he);
    run(8'h1f, 16'h0);
    // ready is sampled one cycle after the reset states end, so read again
    bus(1'b0, fhc_pkg::REG_STATUS, 32'h0);
    check(v & 32'h26, 32'h22);
    print_verdict();
  end
endmodule
bind fhc_flash_host fhc_chk u_chk (.sys_clk, .resetn, .fl_ce_n, .fl_oe_n, .fl_we_n,
  .fl_reset_n, .fl_byte_n, .fl_addr, .fl_dq_out, .fl_dq_oe);
